// >>> sprc_defines.vh
// Register offsets, field positions, reset values and encodings of the serial controller
`ifndef SPRC_DEFINES_VH
`define SPRC_DEFINES_VH

`define SPRC_OFS_CTRL 8'h00
`define SPRC_OFS_FSIZE 8'h04
`define SPRC_OFS_STAT 8'h08
`define SPRC_OFS_ICLR 8'h0c
`define SPRC_OFS_RXPORT 8'h10
`define SPRC_OFS_TXPORT 8'h14
`define SPRC_OFS_DIV 8'h18
`define SPRC_OFS_PSEL 8'h1c
`define SPRC_OFS_MASKED 8'h20
`define SPRC_OFS_RAW 8'h24
`define SPRC_OFS_EMC 8'h28
`define SPRC_OFS_ONESHOT 8'h2c
`define SPRC_OFS_PKT 8'h30
`define SPRC_OFS_CMDSZ 8'h34
`define SPRC_OFS_HWST 8'h38

`define SPRC_RST_CTRL 32'h80000102
`define SPRC_RST_FSIZE 6'h04
`define SPRC_RST_DIV 8'h00

`define SPRC_CTL_HOLD 31
`define SPRC_CTL_OEOFF 30
`define SPRC_CTL_CLKMODE 28
`define SPRC_CTL_FCNT_HI 23
`define SPRC_CTL_FCNT_LO 8
`define SPRC_CTL_IEN_HI 7
`define SPRC_CTL_IEN_LO 4
`define SPRC_CTL_PROTO_HI 3
`define SPRC_CTL_PROTO_LO 2
`define SPRC_CTL_MASTER 1
`define SPRC_CTL_EN 0

`define SPRC_PROTO_FRAMEPULSE 2'b01

`define SPRC_FL_RAW_TX_DONE 0
`define SPRC_FL_RAW_RX_READY 1
`define SPRC_FL_OVFL 2
`define SPRC_FL_UNDR 3
`define SPRC_FL_CMD 4
`define SPRC_FL_SELECT_END_FLAG 5

`define SPRC_EMC_STATUS 0
`define SPRC_EMC_POLL 1
`define SPRC_EMC_FCDIS 2

`define SPRC_OS_FILL 0
`define SPRC_OS_EMPTY 1
`define SPRC_OS_RXRST 2
`define SPRC_OS_TXRST 3
`define SPRC_OS_FCCLR 4
`define SPRC_OS_STALL 5
`define SPRC_OS_RELEASE_TX_IMMEDIATELY 6

`define SPRC_HW_TX_NOT_READY_FLAG 1

`define SPRC_FIFO_AW 3
`define SPRC_FIFO_DEPTH 4'h8

`endif

// >>> sprc_fifo.v
// Eight-word frame buffer with registered head word
`timescale 1ns/1ps
`default_nettype none
`include "sprc_defines.vh"

module sprc_fifo (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire clr,
    input wire push,
    input wire [31:0] din,
    input wire pop,
    output reg [31:0] dout,
    output wire empty,
    output wire full,
    output reg [3:0] count
);
    reg [31:0] mem [0:7];
    reg [`SPRC_FIFO_AW-1:0] wptr;
    reg [`SPRC_FIFO_AW-1:0] rptr;
    wire do_push = push & ~full;
    wire do_pop = pop & ~empty;
    wire [`SPRC_FIFO_AW-1:0] rnext = do_pop ? rptr + 3'h1 : rptr;

    assign empty = (count == 4'h0);
    assign full = (count == `SPRC_FIFO_DEPTH);

    always @(posedge clk) begin
        if (ce && do_push) begin
            mem[wptr] <= din;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr <= 3'h0;
            rptr <= 3'h0;
            count <= 4'h0;
            dout <= 32'h0;
        end else if (ce) begin
            if (clr) begin
                wptr <= 3'h0;
                rptr <= 3'h0;
                count <= 4'h0;
                dout <= 32'h0;
            end else begin
                if (do_push) wptr <= wptr + 3'h1;
                rptr <= rnext;
                count <= count + {3'h0, do_push} - {3'h0, do_pop};
                // Bypass keeps the head fresh when writing into it
                dout <= (do_push && wptr == rnext) ? din : mem[rnext];
            end
        end
    end
endmodule
`default_nettype wire

// >>> sprc_clkdiv.v
// Serial clock half-period tick generator
`timescale 1ns/1ps
`default_nettype none

module sprc_clkdiv (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire run,
    input wire mode,
    input wire [7:0] divider_value,
    output reg tick
);
    reg [15:0] cnt;
    // Half period: 2^div in power mode, div+1 in linear mode
    wire [15:0] half = mode ? {8'h0, divider_value} + 16'h0001 // [R4]
                            : (16'h0001 << divider_value[3:0]); // [R3]

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 16'h0;
            tick <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt <= 16'h0;
                tick <= 1'b0;
            end else if (cnt >= half - 16'h0001) begin
                cnt <= 16'h0;
                tick <= 1'b1;
            end else begin
                cnt <= cnt + 16'h0001;
                tick <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// >>> sprc_core.v
// Serial controller: APB registers, frame engine and packet features
`timescale 1ns/1ps
`default_nettype none
`include "sprc_defines.vh"

// Operation
// (R1) Receive port read returns oldest frame right-aligned and removes it
// (R2) Transmit port write queues the word as next frame
// (R3) Clock mode 0: serial clock is bus clock over 2^(divider+1)
// (R4) Clock mode 1: serial clock is bus clock over 2*(divider+1)
// (R5) Master: select register bit 0 drives the select pin
// (R6) Select pin active low, active high in frame-pulse mode
// (R7) Low four masked bits are raw AND control enables 7:4
// (R8) Masked status is read-only, writes ignored
// (R9) Select-end flag at bit 5 when select goes inactive
// (R10) Command flag at bit 4 after command-size frames in one packet
// (R11) Raw bits: underrun 3, overflow 2, receive ready 1, done 0
// (R12) Frame counter reaching its limit pauses transfer and raises flags; code raises flags and zeroes the counter without pausing
// (R13) Counter disabled: transmit until buffer empties, count field zero
// (R14) Poll mode discards first frame after select goes active
// (R15) Slave status mode sends status word as first frame
// (R16) Transmit-now clears busy status, stays set until first frame sent
// (R17) Auto-stall holds master until packet-size frames queued
// (R18) Counter clear bit zeroes counter; also disable or control write
// (R19) Oneshot bits 3 and 2 reset transmit and receive buffers
// (R20) Auto-empty discards received frames until count or select end
// (R21) Auto-fill pads transmission with zero frames up to count
// (R22) Clear bit 0 clears transmit done flag
// (R23) Clear bits 5..1 clear their flags; clear register reads zero
// (R24) Control holds enables at 7:4 and frame count at 23:8
// (R25) Two-bit protocol field selects serial format
// (R26) Interrupt output is OR of masked status bits
// (R27) Event flags stay set until written one to clear
module sprc_core (
    input wire pclk,
    input wire presetn,
    input wire pclk_en,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire irq,
    output wire serial_clock,
    output wire serial_clock_oe,
    input wire serial_clock_in,
    output wire data_out,
    output wire data_out_oe,
    input wire data_in,
    output wire select_out_pin,
    output wire select_out_oe,
    input wire select_in
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;

    function hit;
        input [7:0] a;
        input [7:0] o;
        begin
            hit = (a == o);
        end
    endfunction

    reg [31:0] ctl_reg;
    reg [5:0] fsize_reg;
    reg [7:0] div_reg;
    reg sel_reg;
    reg [5:0] emc_reg;
    reg [6:0] os_reg;
    reg [7:0] pkt_reg;
    reg [7:0] cmdsz_reg;
    reg [31:0] hws_reg;
    reg [5:0] raw_reg;
    reg [31:0] prdata_reg;
    reg pready_reg;
    reg pslverr_reg;
    reg irq_reg;
    reg sclk_reg;
    reg sclk_oe_reg;
    reg sdo_reg;
    reg sdo_oe_reg;
    reg ssel_reg;
    reg ssel_oe_reg;
    reg sclk_s1, sclk_s2, sclk_s3;
    reg sdi_s1, sdi_s2;
    reg ssi_s1, ssi_s2;
    reg st_reg;
    reg [31:0] txsh_reg;
    reg [31:0] rxsh_reg;
    reg [5:0] bit_cnt_reg;
    reg [15:0] fcnt_reg;
    reg [7:0] ccnt_reg;
    reg first_reg;
    reg ss_d_reg;

    wire [31:0] tx_head;
    wire [31:0] rx_head;
    wire tx_empty, tx_full, rx_empty, rx_full;
    wire [3:0] tx_count;
    wire [3:0] rx_count;
    wire tick;

    // Bus decode
    wire setup = psel & ~penable;
    wire acc = psel & penable & pready_reg;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire wr_os = wr & hit(paddr, `SPRC_OFS_ONESHOT);
    wire wr_ctl = wr & hit(paddr, `SPRC_OFS_CTRL);

    // Mode decode
    wire core_on = ctl_reg[`SPRC_CTL_EN] & ~ctl_reg[`SPRC_CTL_HOLD];
    wire mst = ctl_reg[`SPRC_CTL_MASTER];
    wire [1:0] proto = ctl_reg[`SPRC_CTL_PROTO_HI:`SPRC_CTL_PROTO_LO]; // [R25]
    wire fpulse = (proto == `SPRC_PROTO_FRAMEPULSE);
    wire [15:0] flimit = ctl_reg[`SPRC_CTL_FCNT_HI:`SPRC_CTL_FCNT_LO]; // [R24]
    wire [4:0] msb = fsize_reg[4:0] - 5'h01;

    // Masked view of flags
    wire [5:0] masked_irq_status = raw_reg & {emc_reg[5:4], ctl_reg[`SPRC_CTL_IEN_HI:`SPRC_CTL_IEN_LO]}; // [R7]

    // Select state, both modes
    wire s_act = core_on & ~mst & (fpulse ? ssi_s2 : ~ssi_s2);
    wire ss_now = mst ? (core_on & sel_reg) : s_act;
    wire ss_end = ss_d_reg & ~ss_now;
    wire s_rise = sclk_s2 & ~sclk_s3;
    wire s_fall = ~sclk_s2 & sclk_s3;
    wire [5:0] bit_inc = bit_cnt_reg + 6'h01;

    // Frame start and end
    wire use_status = emc_reg[`SPRC_EMC_STATUS] & ~mst & first_reg; // [R15]
    wire [31:0] load_word = use_status ? hws_reg : (tx_empty ? 32'h0 : tx_head);
    wire short_pkt = ({4'h0, tx_count} < pkt_reg);
    wire m_start = core_on & mst & (st_reg == ST_IDLE) & tick
        & (~tx_empty | os_reg[`SPRC_OS_FILL]) // [R21]
        & ~(os_reg[`SPRC_OS_STALL] & short_pkt); // [R17]
    wire m_fdone = mst & (st_reg == ST_RUN) & tick & sclk_reg & (bit_cnt_reg == fsize_reg);
    wire s_fdone = s_act & s_rise & (bit_inc == fsize_reg);
    wire s_load = s_act & (~ss_d_reg | s_fdone);
    wire fdone = mst ? m_fdone : s_fdone;
    wire tx_pop = (m_start | s_load) & ~use_status & ~tx_empty;
    wire [31:0] rx_word = mst ? rxsh_reg : {rxsh_reg[30:0], sdi_s2};

    // Receive handling
    wire discard = (emc_reg[`SPRC_EMC_POLL] & first_reg) // [R14]
        | os_reg[`SPRC_OS_EMPTY]; // [R20]
    wire rx_push = fdone & ~discard & ~rx_full;
    wire rx_pop = rd & hit(paddr, `SPRC_OFS_RXPORT); // [R1]
    wire tx_push = wr & hit(paddr, `SPRC_OFS_TXPORT); // [R2]
    wire tx_rst = wr_os & pwdata[`SPRC_OS_TXRST]; // [R19]
    wire rx_rst = wr_os & pwdata[`SPRC_OS_RXRST]; // [R19]

    // Frame counter and events
    wire [15:0] fcnt_inc = fcnt_reg + 16'h0001;
    wire fc_on = ~emc_reg[`SPRC_EMC_FCDIS];
    wire fc_hit = fdone & fc_on & (fcnt_inc == flimit); // [R12]
    wire fc_clr = (wr_os & pwdata[`SPRC_OS_FCCLR]) | ~core_on | wr_ctl; // [R18]
    wire [7:0] ccnt_inc = ccnt_reg + 8'h01;
    wire cmd_hit = s_fdone & (cmdsz_reg != 8'h00) & (ccnt_inc == cmdsz_reg); // [R10]
    wire [5:0] set_mask;
    assign set_mask[`SPRC_FL_RAW_TX_DONE] = fc_hit | (~fc_on & fdone & tx_empty); // [R13]
    assign set_mask[`SPRC_FL_RAW_RX_READY] = fc_hit | (~fc_on & rx_push);
    assign set_mask[`SPRC_FL_OVFL] = fdone & ~discard & rx_full;
    assign set_mask[`SPRC_FL_UNDR] = s_load & ~use_status & tx_empty & ~os_reg[`SPRC_OS_FILL];
    assign set_mask[`SPRC_FL_CMD] = cmd_hit;
    assign set_mask[`SPRC_FL_SELECT_END_FLAG] = ss_end; // [R9]
    wire [5:0] clr_mask = (wr & hit(paddr, `SPRC_OFS_ICLR)) ? pwdata[5:0] : 6'h00; // [R22] [R23]

    sprc_fifo u_txq (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pclk_en),
        .clr(tx_rst),
        .push(tx_push),
        .din(pwdata),
        .pop(tx_pop),
        .dout(tx_head),
        .empty(tx_empty),
        .full(tx_full),
        .count(tx_count)
    );

    sprc_fifo u_rxq (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pclk_en),
        .clr(rx_rst),
        .push(rx_push),
        .din(rx_word),
        .pop(rx_pop),
        .dout(rx_head),
        .empty(rx_empty),
        .full(rx_full),
        .count(rx_count)
    );

    sprc_clkdiv u_div (
        .clk(pclk),
        .rst_n(presetn),
        .ce(pclk_en),
        .run(core_on & mst),
        .mode(ctl_reg[`SPRC_CTL_CLKMODE]),
        .divider_value(div_reg),
        .tick(tick)
    );

    // Read data mux
    reg [31:0] rd_mux;
    reg rd_err;
    always @* begin
        rd_mux = 32'h0;
        rd_err = 1'b0;
        if (hit(paddr, `SPRC_OFS_CTRL)) begin
            rd_mux = ctl_reg;
        end else if (hit(paddr, `SPRC_OFS_FSIZE)) begin
            rd_mux = {26'h0, fsize_reg};
        end else if (hit(paddr, `SPRC_OFS_STAT)) begin
            rd_mux = {17'h0, st_reg | s_act, ss_now, 2'h0, tx_empty, 1'b0, tx_full,
                      1'b0, rx_empty, 1'b0, rx_full, raw_reg[3:0]};
        end else if (hit(paddr, `SPRC_OFS_ICLR)) begin
            rd_mux = 32'h0; // [R23]
        end else if (hit(paddr, `SPRC_OFS_RXPORT)) begin
            rd_mux = rx_head;
        end else if (hit(paddr, `SPRC_OFS_TXPORT)) begin
            rd_mux = 32'h0;
        end else if (hit(paddr, `SPRC_OFS_DIV)) begin
            rd_mux = {24'h0, div_reg};
        end else if (hit(paddr, `SPRC_OFS_PSEL)) begin
            rd_mux = {31'h0, sel_reg};
        end else if (hit(paddr, `SPRC_OFS_MASKED)) begin
            rd_mux = {26'h0, masked_irq_status}; // [R8]
        end else if (hit(paddr, `SPRC_OFS_RAW)) begin
            rd_mux = {26'h0, raw_reg}; // [R11]
        end else if (hit(paddr, `SPRC_OFS_EMC)) begin
            rd_mux = {26'h0, emc_reg[5:4], 1'b0, emc_reg[2:0]};
        end else if (hit(paddr, `SPRC_OFS_ONESHOT)) begin
            rd_mux = {25'h0, os_reg[6:5], 3'h0, os_reg[1:0]};
        end else if (hit(paddr, `SPRC_OFS_PKT)) begin
            rd_mux = {24'h0, pkt_reg};
        end else if (hit(paddr, `SPRC_OFS_CMDSZ)) begin
            rd_mux = {24'h0, cmdsz_reg};
        end else if (hit(paddr, `SPRC_OFS_HWST)) begin
            rd_mux = hws_reg;
        end else begin
            rd_err = 1'b1;
        end
    end

    // APB answer: one-cycle access phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (pclk_en) begin
            pready_reg <= setup;
            // Unmapped writes are dropped quietly, only reads are refused
            pslverr_reg <= setup & ~pwrite & rd_err;
            if (setup && !pwrite) prdata_reg <= rd_mux;
        end
    end

    // Software-written registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_reg <= `SPRC_RST_CTRL;
            fsize_reg <= `SPRC_RST_FSIZE;
            div_reg <= `SPRC_RST_DIV;
            sel_reg <= 1'b0;
            emc_reg <= 6'h00;
            pkt_reg <= 8'h00;
            cmdsz_reg <= 8'h00;
            hws_reg <= 32'h0;
        end else if (pclk_en) begin
            if (wr_ctl) ctl_reg <= pwdata;
            if (wr && hit(paddr, `SPRC_OFS_FSIZE) && !core_on) fsize_reg <= pwdata[5:0];
            if (wr && hit(paddr, `SPRC_OFS_DIV)) div_reg <= pwdata[7:0];
            if (wr && hit(paddr, `SPRC_OFS_PSEL)) sel_reg <= pwdata[0];
            if (wr && hit(paddr, `SPRC_OFS_EMC)) emc_reg <= {pwdata[5:4], 1'b0, pwdata[2:0]};
            if (wr && hit(paddr, `SPRC_OFS_PKT)) pkt_reg <= pwdata[7:0];
            if (wr && hit(paddr, `SPRC_OFS_CMDSZ)) cmdsz_reg <= pwdata[7:0];
            if (wr && hit(paddr, `SPRC_OFS_HWST)) begin
                hws_reg <= pwdata;
            end else if (wr_os && pwdata[`SPRC_OS_RELEASE_TX_IMMEDIATELY]) begin
                hws_reg[`SPRC_HW_TX_NOT_READY_FLAG] <= 1'b0; // [R16]
            end
        end
    end

    // Oneshot bits: self-clearing on completion
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            os_reg <= 7'h00;
        end else if (pclk_en) begin
            if (wr_os) begin
                os_reg <= {pwdata[6:5], 3'h0, pwdata[1:0]};
            end else begin
                if (tx_pop) os_reg[`SPRC_OS_RELEASE_TX_IMMEDIATELY] <= 1'b0; // [R16]
                if (m_start) os_reg[`SPRC_OS_STALL] <= 1'b0; // [R17]
                if (fc_hit || (!mst && ss_end)) os_reg[`SPRC_OS_EMPTY] <= 1'b0; // [R20]
                if (fc_hit) os_reg[`SPRC_OS_FILL] <= 1'b0; // [R21]
            end
        end
    end

    // Sticky flags, set beats clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_reg <= 6'h00;
            irq_reg <= 1'b0;
        end else if (pclk_en) begin
            raw_reg <= (raw_reg & ~clr_mask) | set_mask; // [R27]
            irq_reg <= |masked_irq_status; // [R26]
        end
    end

    // Pin synchronisers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            sdi_s1 <= 1'b0;
            sdi_s2 <= 1'b0;
            ssi_s1 <= 1'b1;
            ssi_s2 <= 1'b1;
        end else if (pclk_en) begin
            sclk_s1 <= serial_clock_in;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            sdi_s1 <= data_in;
            sdi_s2 <= sdi_s1;
            ssi_s1 <= select_in;
            ssi_s2 <= ssi_s1;
        end
    end

    // Frame engine
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= ST_IDLE;
            sclk_reg <= 1'b0;
            txsh_reg <= 32'h0;
            rxsh_reg <= 32'h0;
            bit_cnt_reg <= 6'h00;
            fcnt_reg <= 16'h0;
            ccnt_reg <= 8'h00;
            first_reg <= 1'b1;
            ss_d_reg <= 1'b0;
        end else if (pclk_en) begin
            ss_d_reg <= ss_now;
            if (m_start || s_load) begin
                txsh_reg <= load_word;
                rxsh_reg <= 32'h0;
                bit_cnt_reg <= 6'h00;
                if (m_start) st_reg <= ST_RUN;
            end else if (mst && st_reg == ST_RUN && tick) begin
                if (!sclk_reg) begin
                    sclk_reg <= 1'b1;
                    rxsh_reg <= {rxsh_reg[30:0], sdi_s2};
                    bit_cnt_reg <= bit_inc;
                end else begin
                    sclk_reg <= 1'b0;
                    if (bit_cnt_reg == fsize_reg) st_reg <= ST_IDLE;
                    else txsh_reg <= txsh_reg << 1;
                end
            end else if (s_act && s_rise) begin
                rxsh_reg <= {rxsh_reg[30:0], sdi_s2};
                bit_cnt_reg <= bit_inc;
            end else if (s_act && s_fall && bit_cnt_reg != 6'h00) begin
                txsh_reg <= txsh_reg << 1;
            end
            if (!core_on || !mst) begin
                st_reg <= ST_IDLE;
                sclk_reg <= 1'b0;
            end
            if (!ss_now) first_reg <= 1'b1;
            else if (fdone) first_reg <= 1'b0;
            if (fc_clr || fc_hit) fcnt_reg <= 16'h0; // [R18] [R12]
            else if (fdone && fc_on) fcnt_reg <= fcnt_inc;
            if (!s_act || cmd_hit) ccnt_reg <= 8'h00;
            else if (s_fdone) ccnt_reg <= ccnt_inc;
        end
    end

    // Pin drivers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_oe_reg <= 1'b0;
            sdo_reg <= 1'b0;
            sdo_oe_reg <= 1'b0;
            ssel_reg <= 1'b1;
            ssel_oe_reg <= 1'b0;
        end else if (pclk_en) begin
            sclk_oe_reg <= core_on & mst;
            sdo_reg <= txsh_reg[msb];
            sdo_oe_reg <= core_on & (mst | (s_act & ~ctl_reg[`SPRC_CTL_OEOFF]));
            ssel_reg <= fpulse ? (core_on & mst & sel_reg) : ~(core_on & mst & sel_reg); // [R5] [R6]
            ssel_oe_reg <= core_on & mst;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
    assign serial_clock = sclk_reg;
    assign serial_clock_oe = sclk_oe_reg;
    assign data_out = sdo_reg;
    assign data_out_oe = sdo_oe_reg;
    assign select_out_pin = ssel_reg;
    assign select_out_oe = ssel_oe_reg;
endmodule
`default_nettype wire

// >>> sprc_core_checker.sv
// Port-level assertions for the serial controller
`timescale 1ns/1ps
`default_nettype none
module sprc_core_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic serial_clock,
    input wire logic serial_clock_oe,
    input wire logic data_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_setup = psel && !penable && !pwrite;
    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_err: assert property (rd_setup && paddr == 8'h3c |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_err_read: assert property (pslverr |-> pready && !pwrite)
        else $error("error outside a read answer");
    a_clear_zero: assert property (rd_setup && paddr == 8'h0c |=> prdata == 32'h0)
        else $error("clear register read not zero");
    a_mask_upper: assert property (rd_setup && paddr == 8'h20 |=> prdata[31:6] == 26'h0)
        else $error("masked status upper bits set");
    a_raw_upper: assert property (rd_setup && paddr == 8'h24 |=> prdata[31:6] == 26'h0)
        else $error("raw status upper bits set");
    a_oneshot_zero: assert property (rd_setup && paddr == 8'h2c |=> prdata[4:2] == 3'h0)
        else $error("oneshot bits read back set");
    a_sclk_idle: assert property (!serial_clock_oe |-> !serial_clock)
        else $error("serial clock runs undriven");
    a_data_steady: assert property (serial_clock && $past(serial_clock) |-> $stable(data_out))
        else $error("data moved in clock high phase");
    c_error: cover property (pslverr);
    c_clock: cover property ($rose(serial_clock));
    c_irq: cover property (irq);
endmodule
bind sprc_core sprc_core_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .serial_clock(serial_clock),
    .serial_clock_oe(serial_clock_oe), .data_out(data_out));
`default_nettype wire

// >>> sprc_slave_model.sv
// Behavioural serial slave answering one fixed frame
`timescale 1ns/1ps
`default_nettype none
module sprc_slave_model #(
    parameter logic [7:0] RESP = 8'h3c
) (
    input wire logic sclk,
    input wire logic sel_n,
    input wire logic mosi,
    output logic miso,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h0;
    logic last = 1'b0;
    initial got = 8'h0;
    always @(negedge sel_n) sh <= RESP;
    always @(negedge sclk) if (!sel_n) sh <= {sh[6:0], 1'b0};
    always @(posedge sclk) if (!sel_n) got <= {got[6:0], mosi};
    always @(posedge sel_n) last <= sh[7];
    // Released line shows the inverse of its last bit
    assign miso = sel_n ? ~last : sh[7];
endmodule
`default_nettype wire

// >>> spi_register_and_packet_control_bench.sv
// Register-level testbench for the serial controller
`timescale 1ns/1ps
`default_nettype none
module spi_register_and_packet_control_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e = 0, sc_q = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, r;
    logic [7:0] za [6] = '{8'h10, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h2c};
    wire [31:0] prdata;
    wire pready, pslverr, irq, sclk, sclk_oe, dout, dout_oe, ssel, ssel_oe, miso;
    wire [7:0] got;
    int failures = 0, tests_run = 0, cyc = 0, cnt = 0, per = 0;
    always #20 pclk = ~pclk;
    sprc_core i_dut (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .serial_clock(sclk),
        .serial_clock_oe(sclk_oe), .serial_clock_in(1'b0), .data_out(dout),
        .data_out_oe(dout_oe), .data_in(miso), .select_out_pin(ssel),
        .select_out_oe(ssel_oe), .select_in(1'b1));
    sprc_slave_model i_peer (.sclk(sclk), .sel_n(ssel), .mosi(dout), .miso(miso), .got(got));
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Serial clock period in bus cycles, and the hang limit
    always @(posedge pclk) begin
        sc_q <= sclk;
        cnt <= cnt + 1;
        if (sclk && !sc_q) begin
            per <= cnt + 1;
            cnt <= 0;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
        apb(a, 1'b0, 32'h0);
        chk(r & m, x);
        chk({31'h0, e}, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask
    task automatic xfer(input logic [31:0] ctl, input logic [7:0] dv, input int px);
        int n;
        n = 0;
        wr(8'h18, {24'h0, dv});
        rd(8'h18, 32'hffffffff, {24'h0, dv});
        wr(8'h00, ctl);
        wr(8'h1c, 32'h0);
        wr(8'h1c, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, ssel}, 32'h0);
        chk({30'h0, ssel_oe, dout_oe}, 32'h3);
        wr(8'h14, 32'ha5);
        do begin
            apb(8'h24, 1'b0, 32'h0);
            n++;
        end while ((r & 32'h3) != 32'h3 && n < 100);
        chk(r & 32'hf, 32'h3);
        chk({24'h0, got}, 32'ha5);
        chk(per, px);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        foreach (za[i]) rd(za[i], 32'hffffffff, 32'h0);
        rd(8'h00, 32'hffffffff, 32'h80000102);
        apb(8'h3c, 1'b0, 32'h0);
        chk(r, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("test reset done");
        wr(8'h04, 32'h8);
        xfer(32'h000001f3, 8'h2, 8);
        rd(8'h20, 32'hffffffff, 32'h3);
        chk({31'h0, irq}, 32'h1);
        rd(8'h10, 32'hffffffff, 32'h3c);
        rd(8'h08, 32'h40, 32'h40);
        wr(8'h0c, 32'h3f);
        rd(8'h24, 32'h3f, 32'h0);
        rd(8'h0c, 32'hffffffff, 32'h0);
        wr(8'h20, 32'hffffffff);
        rd(8'h20, 32'hffffffff, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test transfer done");
        xfer(32'h100001c3, 8'h4, 10);
        rd(8'h20, 32'hf, 32'h0);
        rd(8'h24, 32'h20, 32'h20);
        wr(8'h0c, 32'h3f);
        $display("test masking done");
        wr(8'h00, 32'h2);
        wr(8'h00, 32'h7);
        repeat (2) @(posedge pclk);
        chk({31'h0, ssel}, 32'h1);
        wr(8'h1c, 32'h0);
        repeat (2) @(posedge pclk);
        chk({31'h0, ssel}, 32'h0);
        $display("test frame pulse done");
        wr(8'h00, 32'h2);
        wr(8'h00, 32'h3);
        wr(8'h30, 32'h4);
        wr(8'h2c, 32'h20);
        wr(8'h14, 32'h1);
        repeat (80) @(posedge pclk);
        rd(8'h08, 32'h400, 32'h0);
        rd(8'h2c, 32'h20, 32'h20);
        wr(8'h2c, 32'h1c);
        rd(8'h2c, 32'h1c, 32'h0);
        rd(8'h08, 32'h440, 32'h440);
        $display("test buffer reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
